/* evl_defines.vh */
// Constants for the event-log register window: offsets, fields, codes
`ifndef EVL_DEFINES_VH
`define EVL_DEFINES_VH

// ----------------------------------------------------------------
// Window offsets, in registers from the window base
// ----------------------------------------------------------------
`define EVL_OFS_ACK_SEQUENCE    16'h0000
`define EVL_OFS_ACK_BLOCK_COUNT 16'h0001
`define EVL_OFS_MARKER_HI       16'h0002
`define EVL_OFS_MARKER_LO       16'h0003
`define EVL_OFS_AREA_LENGTH     16'h0004
`define EVL_OFS_SEQUENCE        16'h0005
`define EVL_OFS_AVAIL_COUNT     16'h0006
`define EVL_OFS_DATA_AREA       16'h0007

// ----------------------------------------------------------------
// Block layout
// ----------------------------------------------------------------
`define EVL_WORDS_PER_BLOCK     4
`define EVL_BLOCK_SHIFT         2
`define EVL_KIND_LSB            0
`define EVL_KIND_MSB            3
`define EVL_KIND_TIME_STAMP     4'h1
`define EVL_KIND_VARIABLE       4'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EVL_RST_WORD            16'h0000
`define EVL_RST_MARKER          32'h0000_0000

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define EVL_DEF_BLOCKS          8
`define EVL_DEF_FIFO_DEPTH      16
`define EVL_ENTRY_WIDTH         96

`endif

/* evl_fifo.v */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module evl_fifo #(
  parameter WIDTH = 96,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

/* evl_window.v */
// Event-log register window: data area, sequence publish and acknowledge
//
// Overview of operation
// - Accesses inside the configured window serve only the event-log protocol.
// - Offset 0 holds the acknowledged sequence, read/write, written by the master.
// - Offset 1 holds the acknowledged block count, read/write, written by the master.
// - Offsets 2-3 read back the internal number of the last event read.
// - Redundant mode uses the marker to skip events already presented.
// - Offset 4 reports data area size in registers, a multiple of four.
// - Offset 5 sequence increments whenever new event data is published.
// - Offset 6 count is loaded with ready blocks when sequence increments.
// - Writing the current sequence to offset 0 acknowledges the whole set.
// - Data area starts at offset 7; block N starts four times N later.
// - Each block takes four registers, kind selected in its first register.
// - Time-stamp blocks carry date, time, reason; variable blocks identity, value.
// - Block kind is 1 for time-stamp blocks, 2 for variable blocks.
`timescale 1ns/1ps
`include "evl_defines.vh"
module evl_window #(
  parameter BLOCKS     = `EVL_DEF_BLOCKS,
  parameter BLK_AW     = 3,
  parameter FIFO_DEPTH = `EVL_DEF_FIFO_DEPTH,
  parameter FIFO_AW    = 4
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Window placement
  input  wire [15:0] window_base,
  // Modbus register access
  input  wire [15:0] reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output wire        reg_hit,
  output reg  [15:0] reg_rdata,
  output reg         reg_rvalid,
  // Event source
  input  wire        event_valid,
  output wire        event_ready,
  input  wire [31:0] event_number,
  input  wire [63:0] event_block,
  // Redundant partner
  input  wire        redundant_mode,
  input  wire        peer_marker_load,
  input  wire [31:0] peer_marker,
  // Status
  output reg  [15:0] published_sequence,
  output reg         awaiting_ack,
  output reg         ack_count_error,
  output reg  [31:0] failover_marker
);

  // ----------------------------------------------------------------
  // Constants and storage
  // ----------------------------------------------------------------
  localparam WORDS   = BLOCKS * `EVL_WORDS_PER_BLOCK;
  localparam WORD_AW = BLK_AW + `EVL_BLOCK_SHIFT;

  localparam ST_COLLECT = 2'h0;
  localparam ST_PUBLISH = 2'h1;
  localparam ST_WAIT    = 2'h2;

  localparam [15:0] AREA_LENGTH = WORDS;
  localparam [15:0] WIN_SIZE    = `EVL_OFS_DATA_AREA + AREA_LENGTH;
  localparam [BLK_AW:0] FULL    = BLOCKS;

  reg [31:0]     area_num [0:BLOCKS-1];
  reg [1:0]      state;
  reg [BLK_AW:0] fill_cnt;
  reg [15:0]     ack_sequence;
  reg [15:0]     ack_block_count;
  reg [15:0]     available_block_count;
  reg            seq_acked;

  // ----------------------------------------------------------------
  // Event buffer
  // ----------------------------------------------------------------
  wire        fifo_valid;
  wire        fifo_pop;
  wire [95:0] fifo_data;

  evl_fifo #(
    .WIDTH (`EVL_ENTRY_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (event_valid),
    .in_ready  (event_ready),
    .in_data   ({event_number, event_block}),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  wire [31:0] head_num  = fifo_data[95:64];
  wire [15:0] head_w0   = fifo_data[15:0];
  wire [3:0]  head_kind = head_w0[`EVL_KIND_MSB:`EVL_KIND_LSB];

  // Only the two defined kinds enter the area
  wire kind_ok = (head_kind == `EVL_KIND_TIME_STAMP) ||
                 (head_kind == `EVL_KIND_VARIABLE);
  // Events at or below the marker were already shown by the partner
  wire stale   = redundant_mode && (head_num <= failover_marker);
  wire room    = (fill_cnt != FULL);

  // Pop while collecting: store good entries, drop bad or stale ones
  assign fifo_pop = fifo_valid && (state == ST_COLLECT) && room;
  wire store      = fifo_pop && kind_ok && !stale;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire [15:0] offset   = reg_addr - window_base;
  wire        in_win   = (reg_addr >= window_base) && (offset < WIN_SIZE);
  assign reg_hit       = in_win;
  wire        wr_hit   = reg_wr && in_win;
  wire [15:0] area_ofs = offset - `EVL_OFS_DATA_AREA;
  wire        in_area  = (offset >= `EVL_OFS_DATA_AREA);

  wire ack_sequence_wr = wr_hit && (offset == `EVL_OFS_ACK_SEQUENCE);
  wire ack_cnt_wr = wr_hit && (offset == `EVL_OFS_ACK_BLOCK_COUNT);
  // Acknowledge only counts against the set now on show
  wire ack_match  = ack_sequence_wr && (state == ST_WAIT) &&
                    (reg_wdata == published_sequence);

  // ----------------------------------------------------------------
  // Data area fill
  // ----------------------------------------------------------------
  // One lane per word of a block, so each array has a single writer
  wire [BLK_AW-1:0]           fill_idx = fill_cnt[BLK_AW-1:0];
  wire [BLK_AW-1:0]           rd_blk   = area_ofs[WORD_AW-1:`EVL_BLOCK_SHIFT];
  wire [`EVL_BLOCK_SHIFT-1:0] rd_lane  = area_ofs[`EVL_BLOCK_SHIFT-1:0];
  wire [63:0]                 lane_rd;

  genvar gi;
  generate
    for (gi = 0; gi < `EVL_WORDS_PER_BLOCK; gi = gi + 1) begin : g_word
      reg [15:0] lane [0:BLOCKS-1];

      always @(posedge clk) begin
        if (store) begin
          lane[fill_idx] <= fifo_data[16*gi +: 16];
        end
      end

      assign lane_rd[16*gi +: 16] = lane[rd_blk];
    end
  endgenerate

  always @(posedge clk) begin
    if (store) begin
      area_num[fill_idx] <= head_num;
    end
  end

  // ----------------------------------------------------------------
  // Sequence control
  // ----------------------------------------------------------------
  // Index of the newest block in the set on show
  wire [BLK_AW-1:0] last_idx = available_block_count[BLK_AW-1:0] - 1'b1;

  always @(posedge clk) begin
    if (!rst_n) begin
      state                 <= ST_COLLECT;
      fill_cnt              <= {(BLK_AW+1){1'b0}};
      published_sequence    <= `EVL_RST_WORD;
      available_block_count <= `EVL_RST_WORD;
      failover_marker       <= `EVL_RST_MARKER;
      awaiting_ack          <= 1'b0;
    end else begin
      case (state)
        ST_COLLECT: begin
          if (store) begin
            fill_cnt <= fill_cnt + 1'b1;
          end
          // Publish once the buffer runs dry or the area is full
          if (fill_cnt != {(BLK_AW+1){1'b0}} && (!fifo_valid || !room)) begin
            state <= ST_PUBLISH;
          end
        end
        ST_PUBLISH: begin
          published_sequence    <= published_sequence + 16'h0001;
          available_block_count <= {{(15-BLK_AW){1'b0}}, fill_cnt};
          awaiting_ack          <= 1'b1;
          state                 <= ST_WAIT;
        end
        ST_WAIT: begin
          if (ack_match) begin
            failover_marker <= area_num[last_idx];
            fill_cnt        <= {(BLK_AW+1){1'b0}};
            awaiting_ack    <= 1'b0;
            state           <= ST_COLLECT;
          end
        end
        default: begin
          state <= ST_COLLECT;
        end
      endcase
      // Partner hand-over outside ST_WAIT takes the marker so stale events are skipped
      if (peer_marker_load && state != ST_WAIT) begin
        failover_marker <= peer_marker;
      end
    end
  end

  // ----------------------------------------------------------------
  // Master-written registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      ack_sequence    <= `EVL_RST_WORD;
      ack_block_count <= `EVL_RST_WORD;
      seq_acked       <= 1'b0;
      ack_count_error <= 1'b0;
    end else begin
      if (ack_sequence_wr) begin
        ack_sequence <= reg_wdata;
        seq_acked    <= ack_match;
      end
      if (ack_cnt_wr) begin
        ack_block_count <= reg_wdata;
        // Count written out of order or not matching the set is flagged
        ack_count_error <= !seq_acked ||
                           (reg_wdata != available_block_count);
        seq_acked       <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read-only offsets have no write path at all, so writes there fall away
  reg [15:0] next_rdata;

  // Area words read as zero outside a published set
  wire area_shown = in_area && (state == ST_WAIT);

  always @* begin
    next_rdata = 16'h0000;
    if (in_win) begin
      case (offset)
        `EVL_OFS_ACK_SEQUENCE:    next_rdata = ack_sequence;
        `EVL_OFS_ACK_BLOCK_COUNT: next_rdata = ack_block_count;
        `EVL_OFS_MARKER_HI:       next_rdata = failover_marker[31:16];
        `EVL_OFS_MARKER_LO:       next_rdata = failover_marker[15:0];
        `EVL_OFS_AREA_LENGTH:     next_rdata = AREA_LENGTH;
        `EVL_OFS_SEQUENCE:        next_rdata = published_sequence;
        `EVL_OFS_AVAIL_COUNT:     next_rdata = available_block_count;
        default: begin
          // Area reads only show data once the set is published
          if (area_shown) begin
            next_rdata = lane_rd[{rd_lane, 4'h0} +: 16];
          end
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd && in_win;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule

/* evl_window_props.sv */
// Concurrent checks on the event-log window ports
`timescale 1ns/1ps
module evl_window_props #(
  parameter BLOCKS = 8
) (
  input wire        clk, rst_n, reg_rd, reg_wr, reg_hit, reg_rvalid, event_ready,
  input wire        awaiting_ack,
  input wire [15:0] window_base, reg_addr, reg_wdata, reg_rdata, published_sequence,
  input wire [31:0] failover_marker
);
  // Offset wraps in 16 bits, so addresses below the base fall outside
  wire [15:0] ofs = reg_addr - window_base;
  wire        rq  = reg_rd && reg_hit;
  wire        ak  = reg_wr && reg_hit && ofs == 16'h0000;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_hit; reg_hit == (ofs < 16'(7 + 4 * BLOCKS)); endproperty
  property p_rv; rq |=> reg_rvalid; endproperty
  property p_nrv; !rq |=> !reg_rvalid; endproperty
  property p_len; rq && ofs == 16'h0004 |=> reg_rdata == 16'(4 * BLOCKS); endproperty
  property p_seq; rq && ofs == 16'h0005 |=> reg_rdata == $past(published_sequence); endproperty
  property p_mk; rq && ofs == 16'h0002 |=> reg_rdata == ($past(failover_marker) >> 16);
  endproperty
  property p_inc; $past(rst_n) && $changed(published_sequence)
    |-> published_sequence == $past(published_sequence) + 16'h0001; endproperty
  property p_pub; $rose(awaiting_ack) |-> $changed(published_sequence); endproperty
  property p_ack; awaiting_ack && ak && reg_wdata == published_sequence |=> !awaiting_ack;
  endproperty
  property p_hold; awaiting_ack && !ak |=> awaiting_ack && $stable(published_sequence);
  endproperty
  a_hit: assert property (p_hit) else $error("window decode wrong");
  a_rv: assert property (p_rv) else $error("read not answered");
  a_nrv: assert property (p_nrv) else $error("stray read answer");
  a_len: assert property (p_len) else $error("area length wrong");
  a_seq: assert property (p_seq) else $error("sequence read wrong");
  a_mk: assert property (p_mk) else $error("marker high word wrong");
  a_inc: assert property (p_inc) else $error("sequence step not one");
  a_pub: assert property (p_pub) else $error("publish without step");
  a_ack: assert property (p_ack) else $error("ack not taken");
  a_hold: assert property (p_hold) else $error("set dropped early");
  c_pub: cover property ($rose(awaiting_ack));
  c_ack: cover property ($fell(awaiting_ack));
  c_full: cover property (!event_ready);
endmodule
bind evl_window evl_window_props #(.BLOCKS(BLOCKS)) u_evl_window_props (
  .clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_hit(reg_hit),
  .reg_rvalid(reg_rvalid), .event_ready(event_ready), .awaiting_ack(awaiting_ack),
  .window_base(window_base), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .published_sequence(published_sequence),
  .failover_marker(failover_marker));

/* evl_master.sv */
// Modbus master model issuing window reads and writes
`timescale 1ns/1ps
module evl_master (
  // Clock and window
  input  wire        clk,
  input  wire [15:0] window_base,
  // Register access
  output reg  [15:0] reg_addr,
  output reg         reg_wr,
  output reg         reg_rd,
  output reg  [15:0] reg_wdata,
  input  wire [15:0] reg_rdata,
  input  wire        reg_rvalid
);
  initial begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  task wr(input [15:0] o, input [15:0] v);
    begin
      @(posedge clk);
      reg_addr <= window_base + o;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      // Stale data must not look like a held value
      reg_wdata <= ~v;
      @(negedge clk);
    end
  endtask
  task rd(input [15:0] o, output [15:0] d, output ok);
    begin
      @(posedge clk);
      reg_addr <= window_base + o;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      ok = reg_rvalid;
      d = reg_rdata;
    end
  endtask
endmodule

/* tb.sv */
// Self-checking bench: window reads, publish, acknowledge, back-pressure
`timescale 1ns/1ps
module tb;
  localparam integer BLK = 8;
  reg         clk, rst_n, ev_v, red, pk_ld, ok, full_seen;
  reg  [15:0] d, s, n;
  reg  [31:0] ev_n, pk_m, seed, num, last;
  reg  [63:0] ev_b;
  reg  [63:0] qb[$];
  reg  [31:0] qn[$];
  wire [15:0] addr, wd, rdat, seq;
  wire        wr, rd, hit, rv, ev_r, aw, cerr;
  wire [31:0] mk;
  integer     bad_count, tests_run, i, k;
  evl_window #(.BLOCKS(BLK)) u_evl_window (
    .clk(clk), .rst_n(rst_n), .window_base(16'h4000), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wd), .reg_hit(hit), .reg_rdata(rdat), .reg_rvalid(rv),
    .event_valid(ev_v), .event_ready(ev_r), .event_number(ev_n), .event_block(ev_b),
    .redundant_mode(red), .peer_marker_load(pk_ld), .peer_marker(pk_m),
    .published_sequence(seq), .awaiting_ack(aw), .ack_count_error(cerr),
    .failover_marker(mk));
  evl_master u_evl_master (
    .clk(clk), .window_base(16'h4000), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wd), .reg_rdata(rdat), .reg_rvalid(rv));
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function good(input [3:0] t);
    good = (t == 4'h1) || (t == 4'h2);
  endfunction
  task print_verdict;
    begin
      if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task r(input [15:0] o);
    begin
      u_evl_master.rd(o, d, ok);
      chk(ok, 1);
    end
  endtask
  // ----------------------------------------------------------------
  // Event source and master rounds
  // ----------------------------------------------------------------
  task push(input integer cnt, input [31:0] thr);
    integer j, w;
    reg [63:0] b;
    begin
      @(posedge clk);
      for (j = 0; j < cnt; j = j + 1) begin
        seed = lfsr(seed);
        b = {seed, lfsr(seed)};
        b[3:0] = (seed[2:0] == 3'h0) ? 4'h5 : {2'b00, seed[4], ~seed[4]};
        num = num + 1;
        // Queued when offered, so pending entries keep the drain loop alive
        if (good(b[3:0]) && num > thr) begin
          qb.push_back(b);
          qn.push_back(num);
        end
        ev_v <= 1'b1;
        ev_n <= num;
        ev_b <= b;
        w = 0;
        @(negedge clk);
        while (ev_r !== 1'b1 && w < 2000) begin
          @(negedge clk);
          w = w + 1;
        end
        @(posedge clk);
      end
      ev_v <= 1'b0;
    end
  endtask
  task drain(input integer mode);
    integer j, w;
    begin
      w = 0;
      while (aw !== 1'b1 && w < 500) begin
        @(negedge clk);
        w = w + 1;
      end
      s = s + 16'h1;
      r(5); chk(d, s);
      r(6); n = d;
      chk(n >= 1 && n <= BLK && n <= qb.size(), 1);
      for (j = 0; j < 4 * n && j < 4 * BLK; j = j + 1) begin
        r(7 + j); chk(d, 16'(qb[j / 4] >> (16 * (j % 4))));
      end
      last = qn[n - 1];
      if (mode == 1) begin
        u_evl_master.wr(5, 16'hBEEF);
        u_evl_master.wr(9, 16'hBEEF);
        r(5); chk(d, s);
        r(9); chk(d, 16'(qb[0] >> 32));
        u_evl_master.wr(2, 16'hBEEF);
        u_evl_master.wr(4, 16'hBEEF);
        u_evl_master.wr(6, 16'hBEEF);
        // No set acknowledged yet, so the marker still holds its reset value
        r(2); chk(d, 0);
        r(4); chk(d, 4 * BLK);
        r(6); chk(d, n);
        u_evl_master.wr(0, s + 16'h1);
        chk(aw, 1);
        u_evl_master.wr(1, n);
        chk(cerr, 1);
      end
      u_evl_master.wr(0, s);
      chk(aw, 0);
      u_evl_master.wr(1, mode == 2 ? n + 16'h1 : n);
      chk(cerr, mode == 2);
      r(0); chk(d, s);
      r(1); chk(d, mode == 2 ? n + 16'h1 : n);
      r(2); chk(d, last >> 16);
      r(3); chk(d, last & 32'hFFFF);
      repeat (n) begin
        qb.pop_front();
        qn.pop_front();
      end
    end
  endtask
  task flush;
    while (qb.size() > 0) drain(0);
  endtask
  always @(negedge clk) if (ev_v && ev_r === 1'b0) full_seen <= 1'b1;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #4000000;
    bad_count = bad_count + 1;
    print_verdict;
  end
  initial begin
    rst_n = 1'b0; ev_v = 1'b0; red = 1'b0; pk_ld = 1'b0; ev_n = 32'h0; ev_b = 64'h0;
    pk_m = 32'h0; seed = 32'h4049AB1E; num = 32'h0; s = 16'h0; full_seen = 1'b0;
    bad_count = 0; tests_run = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    for (i = 0; i < 8; i = i + 1) begin
      r(i); chk(d, i == 4 ? 4 * BLK : 0);
    end
    u_evl_master.rd(7 + 4 * BLK, d, ok); chk(ok, 0);
    u_evl_master.rd(16'hFFFF, d, ok); chk(ok, 0);
    push(5, 0);
    drain(1);
    flush;
    k = 0;
    fork
      push(30, 0);
      begin
        // Master stalls so the area and the FIFO both fill
        repeat (300) @(negedge clk);
        chk(full_seen, 1);
        while (qb.size() > 0) begin
          drain(k == 1 ? 2 : 0);
          k = k + 1;
        end
      end
    join
    flush;
    @(posedge clk);
    red <= 1'b1;
    pk_m <= num + 8;
    pk_ld <= 1'b1;
    @(posedge clk);
    pk_ld <= 1'b0;
    @(negedge clk);
    chk(mk, pk_m);
    push(16, num + 8);
    flush;
    print_verdict;
  end
endmodule
